/* File: common/cbu_pkg.sv */
// Package with encodings, widths and types for the conditional branch unit.
package cbu_pkg;

  // ----------------------------------------------------------------
  // Widths and field positions
  // ----------------------------------------------------------------
  localparam int CBU_PC_W = 21;
  localparam int CBU_INSTR_W = 16;
  localparam int CBU_OPC_HI = 15;
  localparam int CBU_OPC_LO = 8;
  localparam int CBU_OFS_HI = 7;
  localparam int CBU_OFS_LO = 0;

  // ----------------------------------------------------------------
  // Upper-byte encodings of the flag-clear branches
  // ----------------------------------------------------------------
  localparam logic [7:0] CBU_OPC_ZERO_CLR = 8'he1;
  localparam logic [7:0] CBU_OPC_CARRY_CLR = 8'he3;
  localparam logic [7:0] CBU_OPC_OVF_CLR = 8'he5;
  localparam logic [7:0] CBU_OPC_NEG_CLR = 8'he7;

  // ----------------------------------------------------------------
  // Timing counts in quarter phases
  // ----------------------------------------------------------------
  localparam int CBU_PHASES_PER_CYCLE = 4;
  localparam logic [1:0] CBU_NOP_LAST = 2'h3;
  localparam logic [3:0] CBU_LEN_TAKEN = 4'h8;
  localparam logic [3:0] CBU_LEN_NOT_TAKEN = 4'h4;

  // Status flags as seen by the branch unit.
  typedef struct packed {
    logic negative;
    logic overflow;
    logic zero;
    logic carry;
  } cbu_flags_t;

  // Sequencer states; each lasts one quarter phase except CBU_ST_NOP, which lasts four.
  typedef enum logic [2:0] {
    CBU_ST_DECODE,
    CBU_ST_READ,
    CBU_ST_PROC,
    CBU_ST_WRITE,
    CBU_ST_NOP
  } cbu_state_t;

  // True when the instruction is one of the four flag-clear branches.
  function automatic logic cbu_is_branch(input logic [7:0] opc);
    cbu_is_branch = (opc == CBU_OPC_ZERO_CLR) || (opc == CBU_OPC_CARRY_CLR) ||
                    (opc == CBU_OPC_OVF_CLR) || (opc == CBU_OPC_NEG_CLR);
  endfunction : cbu_is_branch

  // True when the flag tested by the opcode reads zero.
  function automatic logic cbu_cond(input logic [7:0] opc, input cbu_flags_t f);
    cbu_cond = 1'b0;
    if (opc == CBU_OPC_ZERO_CLR) cbu_cond = !f.zero;
    else if (opc == CBU_OPC_CARRY_CLR) cbu_cond = !f.carry;
    else if (opc == CBU_OPC_OVF_CLR) cbu_cond = !f.overflow;
    else if (opc == CBU_OPC_NEG_CLR) cbu_cond = !f.negative;
  endfunction : cbu_cond

endpackage : cbu_pkg

/* File: verif/cbu_flag_model.sv */
// Status flag register model standing beside the branch unit.
`timescale 1ns/1ps
`default_nettype none
module cbu_flag_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Flag writes from the preceding instruction
  input wire logic flag_fwd_valid,
  input wire cbu_pkg::cbu_flags_t flag_fwd,
  // Flags as read by the branch unit
  output var cbu_pkg::cbu_flags_t status_flags
);
  import cbu_pkg::*;
  cbu_flags_t flags_ff;
  cbu_flags_t nxt_flags;
  // A write lands only on an enabled edge; the branch itself never writes.
  always_comb
  begin
    nxt_flags = flags_ff;
    if (clk_en && flag_fwd_valid) nxt_flags = flag_fwd;
  end
  // Registers the flags.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n) flags_ff <= '0;
    else flags_ff <= nxt_flags;
  end
  assign status_flags = flags_ff;
endmodule : cbu_flag_model
`default_nettype wire

/* File: verif/conditional_branch_unit_bench.sv */
// Self-checking bench for the conditional branch unit.
`timescale 1ns/1ps
`default_nettype none
module conditional_branch_unit_bench;
  import cbu_pkg::*;
  localparam int W = CBU_PC_W;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [W-1:0] pc_next = '0;
  logic flag_fwd_valid = 1'b0;
  cbu_flags_t flag_fwd = '0;
  cbu_flags_t status_flags;
  logic instr_ready, instr_hit, pc_load, busy, branch_done, branch_taken;
  logic [W-1:0] pc_load_addr;
  int fails = 0;
  int checks_done = 0;
  int seed = 32'h8eda;
  int ticks = 0;
  logic [7:0] opcs [4] = '{CBU_OPC_ZERO_CLR, CBU_OPC_CARRY_CLR, CBU_OPC_OVF_CLR, CBU_OPC_NEG_CLR};
  logic [7:0] offs [4] = '{8'h80, 8'h7f, 8'hff, 8'h00};
  logic [W-1:0] pcs [4] = '{21'h000000, 21'h1ffffe, 21'h000100, 21'h0abcde};
  // ----------------------------------------------------------------
  // Clock, design and partner
  // ----------------------------------------------------------------
  always #4 sys_clk = ~sys_clk;
  cbu_branch_unit u_cbu_branch_unit (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .instr_valid(instr_valid), .instr_word(instr_word), .pc_next(pc_next), .instr_ready(instr_ready),
    .instr_hit(instr_hit), .status_flags(status_flags), .flag_fwd_valid(flag_fwd_valid),
    .flag_fwd(flag_fwd), .pc_load(pc_load), .pc_load_addr(pc_load_addr), .busy(busy),
    .branch_done(branch_done), .branch_taken(branch_taken));
  cbu_flag_model u_cbu_flag_model (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .flag_fwd_valid(flag_fwd_valid), .flag_fwd(flag_fwd), .status_flags(status_flags));
  // ----------------------------------------------------------------
  // Checking and expectation helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Condition: the flag tested by the opcode reads zero.
  function automatic logic exp_cond(input logic [7:0] opc, input cbu_flags_t f);
    case (opc)
      CBU_OPC_ZERO_CLR: exp_cond = !f.zero;
      CBU_OPC_CARRY_CLR: exp_cond = !f.carry;
      CBU_OPC_OVF_CLR: exp_cond = !f.overflow;
      CBU_OPC_NEG_CLR: exp_cond = !f.negative;
      default: exp_cond = 1'b0;
    endcase
  endfunction : exp_cond
  // Target: advanced counter plus the doubled, sign-extended offset.
  function automatic logic [W-1:0] exp_target(input logic [W-1:0] pc, input logic [7:0] ofs);
    exp_target = pc + {{(W-9){ofs[7]}}, ofs, 1'b0};
  endfunction : exp_target
  task automatic conclude();
    $display("Checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // Cuts a hang short.
  always @(posedge sys_clk)
  begin
    ticks++;
    if (ticks == 5000)
    begin
      fails++;
      conclude();
    end
  end
  // One branch from offer to done, counting enabled edges; stall drops clk_en at random.
  task automatic run_branch(input logic [7:0] opc, input logic [7:0] ofs, input logic [W-1:0] pc,
      input cbu_flags_t base, input logic fwd, input cbu_flags_t fval, input logic stall);
    int cyc;
    int len;
    logic tk;
    logic en;
    tk = exp_cond(opc, fwd ? fval : base);
    len = tk ? 8 : 4;
    cyc = 0;
    instr_valid = 1'b1;
    instr_word = {opc, ofs};
    pc_next = pc;
    clk_en = 1'b1;
    flag_fwd_valid = 1'b1;
    flag_fwd = base;
    #1;
    check("instr_hit", 32'(instr_hit), 1);
    while (cyc < len)
    begin
      en = clk_en;
      @(negedge sys_clk);
      if (en) cyc++;
      if (cyc == 1) instr_valid = 1'b0;
      if (cyc < len)
      begin
        flag_fwd_valid = fwd && (cyc == 2);
        flag_fwd = fval;
        clk_en = !stall || (($random(seed) & 3) != 0);
      end
      check("busy", 32'(busy), 32'(cyc < len));
      check("instr_ready", 32'(instr_ready), 32'(cyc == len));
      check("pc_load", 32'(pc_load), 32'(tk && cyc == 3));
      check("branch_done", 32'(branch_done), 32'(cyc == len));
      if (cyc >= 3) check("branch_taken", 32'(branch_taken), 32'(tk));
      if (cyc == 3 && tk) check("pc_load_addr", 32'(pc_load_addr), 32'(exp_target(pc, ofs)));
    end
  endtask : run_branch
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] opc;
    logic [W-1:0] pc;
    repeat (2) @(negedge sys_clk);
    check("reset_out", 32'({busy, pc_load, branch_done, branch_taken, instr_ready}), 32'h1);
    @(negedge sys_clk);
    reset_n = 1'b1;
    // Every opcode with its flag clear and set, boundary offsets and counter wrap.
    for (int i = 0; i < 4; i++)
    begin
      run_branch(opcs[i], offs[i], pcs[i], 4'h0, 1'b0, 4'h0, 1'b0);
      run_branch(opcs[i], offs[3 - i], pcs[i], 4'hf, 1'b0, 4'h0, 1'b0);
    end
    // A flag written by the preceding instruction wins over the stale register.
    run_branch(CBU_OPC_ZERO_CLR, 8'h05, 21'h000200, 4'h0, 1'b1, 4'h2, 1'b0);
    run_branch(CBU_OPC_NEG_CLR, 8'hfb, 21'h000200, 4'h8, 1'b1, 4'h7, 1'b0);
    // Random back-to-back branches, some with clock-enable stalls.
    for (int i = 0; i < 60; i++)
    begin
      pc = W'($random(seed));
      pc[0] = 1'b0;
      run_branch(opcs[$random(seed) & 3], 8'($random(seed)), pc, 4'($random(seed)), 1'($random(seed)),
        4'($random(seed)), 1'($random(seed)));
    end
    // Words outside the four opcodes, set-flag neighbours among them, are never claimed and leave the unit idle.
    for (int i = 0; i < 8; i++)
    begin
      opc = (i < 4) ? (opcs[i] ^ 8'h01) : (8'($random(seed)) & 8'hfe);
      instr_valid = 1'b1;
      instr_word = {opc, 8'($random(seed))};
      clk_en = 1'b1;
      repeat (2) @(negedge sys_clk);
      check("instr_hit", 32'(instr_hit), 0);
      check("busy", 32'(busy), 0);
    end
    instr_valid = 1'b0;
    conclude();
  end
endmodule : conditional_branch_unit_bench
`default_nettype wire

/* File: verilog/cbu_branch_unit.sv */
// Conditional branch unit for the four flag-clear short relative branches.
`timescale 1ns/1ps
`default_nettype none
module cbu_branch_unit #(
  parameter int PC_W = cbu_pkg::CBU_PC_W
) (
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Instruction from the fetch stage
  input wire logic instr_valid,
  input wire logic [cbu_pkg::CBU_INSTR_W-1:0] instr_word,
  input wire logic [PC_W-1:0] pc_next,
  output logic instr_ready,
  output logic instr_hit,
  // Status flags and writes from the preceding instruction
  input wire cbu_pkg::cbu_flags_t status_flags,
  input wire logic flag_fwd_valid,
  input wire cbu_pkg::cbu_flags_t flag_fwd,
  // Program counter load
  output logic pc_load,
  output logic [PC_W-1:0] pc_load_addr,
  // Status
  output logic busy,
  output logic branch_done,
  output logic branch_taken
);
  import cbu_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cbu_state_t state_ff, nxt_state;
  logic [7:0] opc_ff, nxt_opc;
  logic [7:0] ofs_ff, nxt_ofs;
  logic [PC_W-1:0] base_ff, nxt_base;
  cbu_flags_t flags_ff, nxt_flags;
  logic taken_ff, nxt_taken;
  logic [1:0] nop_cnt_ff, nxt_nop_cnt;
  logic pc_load_ff, nxt_pc_load;
  logic [PC_W-1:0] pc_addr_ff, nxt_pc_addr;
  logic done_ff, nxt_done;
  logic [PC_W-1:0] target;
  logic accept;

  // Target adder on the latched counter and offset.
  cbu_target_calc #(.PC_W(PC_W)) u_target (
    .pc_base(base_ff),
    .offset(ofs_ff),
    .target(target)
  );

  // ----------------------------------------------------------------
  // Handshake with fetch
  // ----------------------------------------------------------------
  // Only the four flag-clear branches are claimed; others pass untouched.
  always_comb
  begin
    instr_hit = cbu_is_branch(instr_word[CBU_OPC_HI:CBU_OPC_LO]);
    instr_ready = (state_ff == CBU_ST_DECODE);
    accept = clk_en && instr_valid && instr_hit && instr_ready;
  end

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  // One state per quarter phase, four in CBU_ST_NOP; clk_en low freezes everything.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_opc = opc_ff;
    nxt_ofs = ofs_ff;
    nxt_base = base_ff;
    nxt_flags = flags_ff;
    nxt_taken = taken_ff;
    nxt_nop_cnt = nop_cnt_ff;
    nxt_pc_load = pc_load_ff;
    nxt_pc_addr = pc_addr_ff;
    // The done pulse is state too: it holds while the enable is low.
    nxt_done = done_ff;
    if (clk_en)
    begin
      nxt_pc_load = 1'b0;
      nxt_done = 1'b0;
      case (state_ff)
        CBU_ST_DECODE:
        begin
          // Decode phase: latch opcode, offset and the already advanced counter.
          if (accept)
          begin
            nxt_opc = instr_word[CBU_OPC_HI:CBU_OPC_LO];
            nxt_ofs = instr_word[CBU_OFS_HI:CBU_OFS_LO];
            nxt_base = pc_next;
            nxt_state = CBU_ST_READ;
          end
        end
        CBU_ST_READ:
        begin
          // Offset literal is read; flags are sampled in the next phase.
          nxt_state = CBU_ST_PROC;
        end
        CBU_ST_PROC:
        begin
          // Flags written by the preceding instruction take precedence.
          nxt_flags = flag_fwd_valid ? flag_fwd : status_flags;
          nxt_taken = cbu_cond(opc_ff, nxt_flags);
          nxt_pc_load = nxt_taken;
          nxt_pc_addr = nxt_taken ? target : pc_addr_ff;
          nxt_state = CBU_ST_WRITE;
        end
        CBU_ST_WRITE:
        begin
          // Fourth phase writes the counter when taken, else idles and ends.
          nxt_nop_cnt = 2'h0;
          nxt_state = taken_ff ? CBU_ST_NOP : CBU_ST_DECODE;
          nxt_done = !taken_ff;
        end
        CBU_ST_NOP:
        begin
          // Second instruction cycle of four idle phases.
          nxt_nop_cnt = nop_cnt_ff + 2'h1;
          if (nop_cnt_ff == CBU_NOP_LAST)
          begin
            nxt_state = CBU_ST_DECODE;
            nxt_done = 1'b1;
          end
        end
        default:
        begin
          nxt_state = CBU_ST_DECODE;
        end
      endcase
    end
  end

  // Registers of the sequencer.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff <= CBU_ST_DECODE;
      opc_ff <= 8'h00;
      ofs_ff <= 8'h00;
      base_ff <= '0;
      flags_ff <= '0;
      taken_ff <= 1'b0;
      nop_cnt_ff <= 2'h0;
      pc_load_ff <= 1'b0;
      pc_addr_ff <= '0;
      done_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      opc_ff <= nxt_opc;
      ofs_ff <= nxt_ofs;
      base_ff <= nxt_base;
      flags_ff <= nxt_flags;
      taken_ff <= nxt_taken;
      nop_cnt_ff <= nxt_nop_cnt;
      pc_load_ff <= nxt_pc_load;
      pc_addr_ff <= nxt_pc_addr;
      done_ff <= nxt_done;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The unit has no path to the status register, so no flag is written.
  always_comb
  begin
    pc_load = pc_load_ff;
    pc_load_addr = pc_addr_ff;
    busy = (state_ff != CBU_ST_DECODE);
    branch_done = done_ff;
    branch_taken = taken_ff;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Enabled phases since the accept, for the cycle-count check.
  logic [3:0] run_len_ff;
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n) run_len_ff <= 4'h0;
    else if (accept) run_len_ff <= 4'h1;
    else if (clk_en && busy) run_len_ff <= run_len_ff + 4'h1;
  end

  property p_target;
    pc_load |-> pc_load_addr == base_ff + {{(PC_W-9){ofs_ff[7]}}, ofs_ff, 1'b0};
  endproperty
  a_target: assert property (p_target) else $error("branch target wrong");

  property p_range;
    pc_load |-> (pc_load_addr[0] == base_ff[0]) && (pc_load_addr != base_ff + 21'h100);
  endproperty
  a_range: assert property (p_range) else $error("displacement out of range");

  property p_neg;
    (state_ff == CBU_ST_WRITE && opc_ff == CBU_OPC_NEG_CLR) |-> taken_ff == !flags_ff.negative;
  endproperty
  a_neg: assert property (p_neg) else $error("negative-clear condition wrong");

  property p_ovf;
    (state_ff == CBU_ST_WRITE && opc_ff == CBU_OPC_OVF_CLR) |-> taken_ff == !flags_ff.overflow;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow-clear condition wrong");

  property p_zero;
    (state_ff == CBU_ST_WRITE && opc_ff == CBU_OPC_ZERO_CLR) |-> taken_ff == !flags_ff.zero;
  endproperty
  a_zero: assert property (p_zero) else $error("zero-clear condition wrong");

  property p_len;
    branch_done |-> run_len_ff == (taken_ff ? CBU_LEN_TAKEN : CBU_LEN_NOT_TAKEN);
  endproperty
  a_len: assert property (p_len) else $error("instruction length wrong");

  // Third enabled phase after the accept is the write phase, however long the stalls.
  property p_write_phase;
    (busy && run_len_ff == (CBU_LEN_NOT_TAKEN - 4'h1))
      |-> state_ff == CBU_ST_WRITE && pc_load == taken_ff;
  endproperty
  a_write_phase: assert property (p_write_phase) else $error("counter write not in fourth phase");

  property p_carry;
    (state_ff == CBU_ST_WRITE && opc_ff == CBU_OPC_CARRY_CLR) |-> taken_ff == !flags_ff.carry;
  endproperty
  a_carry: assert property (p_carry) else $error("carry-clear condition wrong");

  property p_fwd;
    (state_ff == CBU_ST_PROC && clk_en && flag_fwd_valid) |=> flags_ff == $past(flag_fwd);
  endproperty
  a_fwd: assert property (p_fwd) else $error("forwarded flags not used");

  c_taken: cover property (accept ##[1:40] (branch_done && taken_ff));
  c_not_taken: cover property (accept ##[1:40] (branch_done && !taken_ff));
  c_fwd: cover property (state_ff == CBU_ST_PROC && clk_en && flag_fwd_valid);

endmodule : cbu_branch_unit
`default_nettype wire

/* File: verilog/cbu_target_calc.sv */
// Branch target adder: incremented counter plus doubled signed offset.
`timescale 1ns/1ps
`default_nettype none
module cbu_target_calc #(
  parameter int PC_W = cbu_pkg::CBU_PC_W
) (
  // Operands
  input wire logic [PC_W-1:0] pc_base,
  input wire logic [7:0] offset,
  // Result
  output logic [PC_W-1:0] target
);
  import cbu_pkg::*;

  // ----------------------------------------------------------------
  // Sign extension and doubling
  // ----------------------------------------------------------------
  logic [PC_W-1:0] disp;

  // The offset spans -128..127 and becomes a byte displacement of 2n.
  always_comb
  begin
    disp = {{(PC_W-9){offset[7]}}, offset, 1'b0};
    target = pc_base + disp;
  end

endmodule : cbu_target_calc
`default_nettype wire
